// [shared/mdi_consts.svh]
// mdi_consts.svh: offsets, field positions, reset values, sizes
// assumes: included by the package and the top module by bare name
`ifndef MDI_CONSTS_SVH
`define MDI_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define MDI_IDX_SUPPLY      8'h44
`define MDI_IDX_CLOCK       8'h45
`define MDI_IDX_DIGITAL     8'h46
`define MDI_IDX_IRQ_STATUS  8'h50
`define MDI_IDX_IRQ_MASK    8'h51
`define MDI_IDX_FAULT_STATE 8'h52

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define MDI_RST_SUPPLY      16'h0000
`define MDI_RST_CLOCK       16'h0000
`define MDI_RST_DIGITAL     16'h0000
`define MDI_WMASK_SUPPLY    16'hFF87
`define MDI_WMASK_CLOCK     16'hFFFF
`define MDI_WMASK_DIGITAL   16'h0307

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MDI_SUP_GROUND_A    2
`define MDI_SUP_GROUND_B    1
`define MDI_SUP_DIG_GROUND  0
`define MDI_CLK_OVERFREQ    3
`define MDI_CLK_UNDERFREQ   2
`define MDI_CLK_AUX_WD      1
`define MDI_CLK_MAIN_WD     0
`define MDI_DIG_CRC_HI      9
`define MDI_DIG_CRC_LO      8
`define MDI_DIG_GROUP_A     2
`define MDI_DIG_GROUP_B     1
`define MDI_DIG_GROUP_BASE  0

// ----------------------------------------------------------------
// sizes and codes
// ----------------------------------------------------------------
`define MDI_EVT_W           7
`define MDI_PINS            3
`define MDI_DIR_W           2
`define MDI_DIR_DIG_OUT     2'h1

`endif

// [shared/mdi_pkg.sv]
// mdi_pkg: carrier types of the monitor diagnostic injection block
// assumes: mdi_consts.svh is on the include path
`include "mdi_consts.svh"

package mdi_pkg;

	// one bit per safety monitor
	typedef struct packed {
		logic ground_a_open;
		logic ground_b_open;
		logic digital_ground_open;
		logic main_clock_freq;
		logic aux_osc_watchdog;
		logic main_clock_watchdog;
	} mdi_mon_t;

	// injection drives towards the monitors
	typedef struct packed {
		logic ground_a_open_test_enable;
		logic ground_b_open_test_enable;
		logic digital_ground_open_test_enable;
		logic main_clock_overfreq_test_enable;
		logic main_clock_underfreq_test_enable;
		logic aux_osc_watchdog_test_enable;
		logic main_clock_watchdog_test_enable;
		logic [1:0] regmap_crc_test_pattern;
	} mdi_inject_t;

	// active-low fault flags
	typedef struct packed {
		logic ground_a_open_fault_n;
		logic ground_b_open_fault_n;
		logic digital_ground_open_fault_n;
		logic main_clock_freq_fault_n;
		logic aux_osc_watchdog_fault_n;
		logic main_clock_watchdog_fault_n;
		logic regmap_crc_fault_n;
	} mdi_fault_t;

	// one pin group: two data bits and a direction code per pin
	typedef struct packed {
		logic [`MDI_PINS-1:0][1:0]            value;
		logic [`MDI_PINS-1:0][`MDI_DIR_W-1:0] direction;
	} mdi_pins_t;

	// register words covered by the register-map crc
	typedef struct packed {
		logic [15:0] supply_check_injection;
		logic [15:0] clock_check_injection;
		logic [15:0] digital_check_injection;
	} mdi_image_t;

endpackage

// [src/mdi_top.sv]
// mdi_top: diagnostic injection registers for the safety monitors,
// register-map crc test selection and pin readback inversion
// assumes: apb master on sys_clk, monitors and crc checker outside
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "mdi_consts.svh"

module mdi_top
	import mdi_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// monitors
	input  wire mdi_pkg::mdi_mon_t    monitor_enable,
	input  wire mdi_pkg::mdi_mon_t    monitor_trip,
	input  wire logic                 crc_mismatch,
	output mdi_pkg::mdi_inject_t      inject,
	output mdi_pkg::mdi_fault_t       fault_flags,
	output mdi_pkg::mdi_image_t       crc_image,
	// pin groups
	input  wire mdi_pkg::mdi_pins_t   pin_group_a,
	input  wire mdi_pkg::mdi_pins_t   pin_group_b,
	input  wire mdi_pkg::mdi_pins_t   pin_group_base,
	output logic [`MDI_PINS-1:0][1:0] pin_group_a_value,
	output logic [`MDI_PINS-1:0][1:0] pin_group_b_value,
	output logic [`MDI_PINS-1:0][1:0] pin_group_base_value,
	// interrupt
	output logic                      irq
);
	import mdi_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		addr_is = (a == ADDR_W'({idx, 2'b00}));
	endfunction

	// invert data of pins driven as digital outputs
	function automatic logic [`MDI_PINS-1:0][1:0] readback(
		input mdi_pins_t g, input logic inv);
		logic [`MDI_PINS-1:0][1:0] r;
		r = g.value;
		for (int i = 0; i < `MDI_PINS; i++) begin
			if (inv && g.direction[i] == `MDI_DIR_DIG_OUT) begin
				r[i] = ~g.value[i];
			end
		end
		readback = r;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0]           supply_q, supply_d;
	logic [15:0]           clock_q, clock_d;
	logic [15:0]           digital_q, digital_d;
	logic [`MDI_EVT_W-1:0] status_q, status_d;
	logic [`MDI_EVT_W-1:0] mask_q, mask_d;
	logic [`MDI_EVT_W-1:0] fault_q, fault_d;
	logic [`MDI_EVT_W-1:0] evt;
	logic [31:0]           prdata_d;
	logic                  pready_d, pslverr_d, irq_d;
	logic                  wr;
	logic                  mapped;
	mdi_inject_t           inject_d;
	mdi_fault_t            fault_n_d;
	logic [`MDI_PINS-1:0][1:0] rb_a_d, rb_b_d, rb_base_d;

	// ------------------------------------------------------------
	// apb slave and registers
	// ------------------------------------------------------------
	// answer in the first access cycle; no wait states
	always_comb begin
		supply_d  = supply_q;
		clock_d   = clock_q;
		digital_d = digital_q;
		mask_d    = mask_q;
		prdata_d  = prdata;
		pslverr_d = 1'b0;
		pready_d  = 1'b0;
		mapped    = addr_is(paddr, `MDI_IDX_SUPPLY)
			|| addr_is(paddr, `MDI_IDX_CLOCK)
			|| addr_is(paddr, `MDI_IDX_DIGITAL)
			|| addr_is(paddr, `MDI_IDX_IRQ_STATUS)
			|| addr_is(paddr, `MDI_IDX_IRQ_MASK)
			|| addr_is(paddr, `MDI_IDX_FAULT_STATE);
		wr = psel && penable && pready && pwrite && !pslverr;
		if (psel && !penable) begin
			pready_d  = 1'b1;
			pslverr_d = !mapped;
			prdata_d  = 32'h0000_0000;
			if (!pwrite) begin
				if (addr_is(paddr, `MDI_IDX_SUPPLY)) begin
					prdata_d = {16'h0000, supply_q};
				end
				if (addr_is(paddr, `MDI_IDX_CLOCK)) begin
					prdata_d = {16'h0000, clock_q};
				end
				if (addr_is(paddr, `MDI_IDX_DIGITAL)) begin
					prdata_d = {16'h0000, digital_q};
				end
				if (addr_is(paddr, `MDI_IDX_IRQ_STATUS)) begin
					prdata_d = {25'h0000000, status_q};
				end
				if (addr_is(paddr, `MDI_IDX_IRQ_MASK)) begin
					prdata_d = {25'h0000000, mask_q};
				end
				if (addr_is(paddr, `MDI_IDX_FAULT_STATE)) begin
					prdata_d = {25'h0000000, fault_q};
				end
			end
		end
		if (wr && addr_is(paddr, `MDI_IDX_SUPPLY)) begin
			supply_d = pwdata[15:0] & `MDI_WMASK_SUPPLY;
		end
		if (wr && addr_is(paddr, `MDI_IDX_CLOCK)) begin
			clock_d = pwdata[15:0] & `MDI_WMASK_CLOCK;
		end
		if (wr && addr_is(paddr, `MDI_IDX_DIGITAL)) begin
			digital_d = pwdata[15:0] & `MDI_WMASK_DIGITAL;
		end
		if (wr && addr_is(paddr, `MDI_IDX_IRQ_MASK)) begin
			mask_d = pwdata[`MDI_EVT_W-1:0];
		end
		// write-one-clear; a new event in the same cycle survives
		status_d = status_q;
		if (wr && addr_is(paddr, `MDI_IDX_IRQ_STATUS)) begin
			status_d = status_q & ~pwdata[`MDI_EVT_W-1:0];
		end
		status_d = status_d | evt;
		irq_d    = |(status_d & mask_d);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			supply_q  <= `MDI_RST_SUPPLY;
			clock_q   <= `MDI_RST_CLOCK;
			digital_q <= `MDI_RST_DIGITAL;
			status_q  <= '0;
			mask_q    <= '0;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			irq       <= 1'b0;
		end else begin
			supply_q  <= supply_d;
			clock_q   <= clock_d;
			digital_q <= digital_d;
			status_q  <= status_d;
			mask_q    <= mask_d;
			prdata    <= prdata_d;
			pready    <= pready_d;
			pslverr   <= pslverr_d;
			irq       <= irq_d;
		end
	end

	// ------------------------------------------------------------
	// injection and fault flags
	// ------------------------------------------------------------
	// injection is a level of the register bits, all but the crc test pattern gated by the monitor enables, so clearing a
	// bit releases the monitor on the next edge
	always_comb begin
		inject_d = '0;
		inject_d.ground_a_open_test_enable =
			supply_q[`MDI_SUP_GROUND_A]
			& monitor_enable.ground_a_open;
		inject_d.ground_b_open_test_enable =
			supply_q[`MDI_SUP_GROUND_B]
			& monitor_enable.ground_b_open;
		inject_d.digital_ground_open_test_enable =
			supply_q[`MDI_SUP_DIG_GROUND]
			& monitor_enable.digital_ground_open;
		inject_d.main_clock_overfreq_test_enable =
			clock_q[`MDI_CLK_OVERFREQ]
			& monitor_enable.main_clock_freq;
		inject_d.main_clock_underfreq_test_enable =
			clock_q[`MDI_CLK_UNDERFREQ]
			& monitor_enable.main_clock_freq;
		inject_d.aux_osc_watchdog_test_enable =
			clock_q[`MDI_CLK_AUX_WD]
			& monitor_enable.aux_osc_watchdog;
		inject_d.main_clock_watchdog_test_enable =
			clock_q[`MDI_CLK_MAIN_WD]
			& monitor_enable.main_clock_watchdog;
		inject_d.regmap_crc_test_pattern =
			digital_q[`MDI_DIG_CRC_HI:`MDI_DIG_CRC_LO];

		// fault vector, bit order matches the status register
		fault_d[6] = crc_mismatch
			|| inject_d.regmap_crc_test_pattern != 2'h0;
		fault_d[5] = monitor_enable.main_clock_freq
			& (monitor_trip.main_clock_freq
			| inject_d.main_clock_overfreq_test_enable
			| inject_d.main_clock_underfreq_test_enable);
		fault_d[4] = monitor_enable.aux_osc_watchdog
			& (monitor_trip.aux_osc_watchdog
			| inject_d.aux_osc_watchdog_test_enable);
		fault_d[3] = monitor_enable.main_clock_watchdog
			& (monitor_trip.main_clock_watchdog
			| inject_d.main_clock_watchdog_test_enable);
		fault_d[2] = monitor_enable.ground_a_open
			& (monitor_trip.ground_a_open
			| inject_d.ground_a_open_test_enable);
		fault_d[1] = monitor_enable.ground_b_open
			& (monitor_trip.ground_b_open
			| inject_d.ground_b_open_test_enable);
		fault_d[0] = monitor_enable.digital_ground_open
			& (monitor_trip.digital_ground_open
			| inject_d.digital_ground_open_test_enable);
		evt = fault_d & ~fault_q;
		// flag order follows the struct, not the status layout
		fault_n_d = '{!fault_d[2], !fault_d[1], !fault_d[0],
			!fault_d[5], !fault_d[4], !fault_d[3], !fault_d[6]};

		rb_a_d    = readback(pin_group_a,
			digital_q[`MDI_DIG_GROUP_A]);
		rb_b_d    = readback(pin_group_b,
			digital_q[`MDI_DIG_GROUP_B]);
		rb_base_d = readback(pin_group_base,
			digital_q[`MDI_DIG_GROUP_BASE]);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fault_q              <= '0;
			inject               <= '0;
			fault_flags          <= '1;
			crc_image            <= '0;
			pin_group_a_value    <= '0;
			pin_group_b_value    <= '0;
			pin_group_base_value <= '0;
		end else begin
			fault_q     <= fault_d;
			inject      <= inject_d;
			fault_flags <= fault_n_d;
			// spare bits reach the crc like any other stored bit
			crc_image.supply_check_injection  <= supply_d;
			crc_image.clock_check_injection   <= clock_d;
			crc_image.digital_check_injection <= digital_d;
			pin_group_a_value    <= rb_a_d;
			pin_group_b_value    <= rb_b_d;
			pin_group_base_value <= rb_base_d;
		end
	end

endmodule // mdi_top

// [tb/mdi_apb_host.sv]
// mdi_apb_host: register bus master standing in for the host
// assumes: one transfer at a time, entered right after a clock edge
`timescale 1ns/1ps
module mdi_apb_host (
	// clock
	input  wire logic   sys_clk,
	// apb master
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [9:0]  paddr,
	output logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic   pready,
	input  wire logic   pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	task automatic xfer(input logic [9:0] a, input logic wr,
		input logic [31:0] w, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		// never both frequency tests at once: overfreq wins
		pwdata <= (a == 10'h114 && w[3]) ? (w & ~32'h4) : w;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		// only the bench watchdog ends a stalled wait
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup never lands on the release
		@(posedge sys_clk);
	endtask
endmodule // mdi_apb_host

// [tb/mdi_check_monitor.sv]
// mdi_check_monitor: port-level assertions for mdi_top
// assumes: bound to mdi_top, single clock sys_clk
`timescale 1ns/1ps
module mdi_check_monitor
	import mdi_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	// clock, reset and apb
	input wire logic                sys_clk,
	input wire logic                srst,
	input wire logic                pwrite,
	input wire logic [ADDR_W-1:0]   paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// monitors and pins
	input wire mdi_pkg::mdi_mon_t    monitor_enable,
	input wire mdi_pkg::mdi_inject_t inject,
	input wire mdi_pkg::mdi_fault_t  fault_flags,
	input wire mdi_pkg::mdi_pins_t   pin_group_a,
	input wire logic [2:0][1:0]     pin_group_a_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	gnd_gate_a: assert property (
		!$past(monitor_enable.ground_a_open)
		|-> !inject.ground_a_open_test_enable) else $error("ungated");
	dig_fault_a: assert property (
		inject.digital_ground_open_test_enable
		|-> !fault_flags.digital_ground_open_fault_n) else $error("no flag");
	freq_fault_a: assert property (
		(inject.main_clock_overfreq_test_enable
		|| inject.main_clock_underfreq_test_enable)
		|-> !fault_flags.main_clock_freq_fault_n) else $error("no flag");
	aux_fault_a: assert property (
		inject.aux_osc_watchdog_test_enable
		|-> !fault_flags.aux_osc_watchdog_fault_n) else $error("no flag");
	wd_fault_a: assert property (
		inject.main_clock_watchdog_test_enable
		|-> !fault_flags.main_clock_watchdog_fault_n)
		else $error("no flag");
	gnd_b_fault_a: assert property (
		inject.ground_b_open_test_enable
		|-> !fault_flags.ground_b_open_fault_n) else $error("no flag");
	crc_fault_a: assert property (
		inject.regmap_crc_test_pattern != 2'h0
		|-> !fault_flags.regmap_crc_fault_n) else $error("no flag");
	resv_zero_a: assert property (
		pready && !pwrite && paddr == 'h118
		|-> prdata[15:10] == 6'h00 && prdata[7:3] == 5'h00)
		else $error("reserved set");
	// pin 1 is not an output, so it must never be inverted
	pin_readback_a: assert property (
		!$past(srst) && $past(pin_group_a.direction[1]) != 2'h1
		|-> pin_group_a_value[1] == $past(pin_group_a.value[1]))
		else $error("bad readback");
	err_seen_c: cover property (pslverr);
	crc_three_c: cover property (inject.regmap_crc_test_pattern == 2'h3);
	freq_trip_c: cover property (!fault_flags.main_clock_freq_fault_n);
endmodule // mdi_check_monitor

bind mdi_top mdi_check_monitor #(.ADDR_W(ADDR_W)) check_i (.sys_clk,
	.srst, .pwrite, .paddr, .prdata, .pready, .pslverr, .monitor_enable,
	.inject, .fault_flags, .pin_group_a, .pin_group_a_value);

// [tb/monitor_diagnostic_injection_tb_top.sv]
// monitor_diagnostic_injection_tb_top: self-checking bench of mdi_top
// assumes: mdi_apb_host on the bus, monitor trips and crc errors idle
`timescale 1ns/1ps
module monitor_diagnostic_injection_tb_top;
	import mdi_pkg::*;
	typedef struct packed {
		logic [9:0]  a;
		logic [15:0] w;
		logic [15:0] r;
		logic [6:0]  f;
		logic [17:0] p;
	} mdi_row_t;
	// pins 2 and 0 are outputs, pin 1 is not
	localparam mdi_pins_t PINS = 12'hE51;
	logic            sys_clk = 1'b0;
	logic            srst = 1'b1;
	logic            psel, penable, pwrite, pready, pslverr, irq, rerr;
	logic [9:0]      paddr;
	logic [31:0]     pwdata, prdata, rdat;
	mdi_mon_t        mon_en = '1;
	mdi_inject_t     inject;
	mdi_fault_t      fault_flags;
	mdi_image_t      crc_img;
	logic [2:0][1:0] a_v, b_v, base_v;
	int              num_errors = 0;
	int              checks = 0;
	mdi_row_t        rows [14] = '{
		'{10'h110, 16'hFFFC, 16'hFF84, 7'h3F, 18'h39E79},
		'{10'h110, 16'h0002, 16'h0002, 7'h5F, 18'h39E79},
		'{10'h110, 16'h0001, 16'h0001, 7'h6F, 18'h39E79},
		'{10'h110, 16'h0000, 16'h0000, 7'h7F, 18'h39E79},
		'{10'h114, 16'hABC8, 16'hABC8, 7'h77, 18'h39E79},
		'{10'h114, 16'h0004, 16'h0004, 7'h77, 18'h39E79},
		'{10'h114, 16'h0002, 16'h0002, 7'h7B, 18'h39E79},
		'{10'h114, 16'h0001, 16'h0001, 7'h7D, 18'h39E79},
		'{10'h114, 16'h0000, 16'h0000, 7'h7F, 18'h39E79},
		'{10'h118, 16'h0101, 16'h0101, 7'h7E, 18'h39E4A},
		'{10'h118, 16'h0202, 16'h0202, 7'h7E, 18'h392B9},
		'{10'h118, 16'h0304, 16'h0304, 7'h7E, 18'h0AE79},
		'{10'h118, 16'hFFFF, 16'h0307, 7'h7E, 18'h0A28A},
		'{10'h118, 16'h0000, 16'h0000, 7'h7F, 18'h39E79}};

	always #5 sys_clk = ~sys_clk;

	mdi_top #(.ADDR_W(10)) uut (.sys_clk, .srst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.monitor_enable(mon_en), .monitor_trip('0), .crc_mismatch(1'b0),
		.inject, .fault_flags, .crc_image(crc_img),
		.pin_group_a(PINS),
		.pin_group_b(PINS), .pin_group_base(PINS), .pin_group_a_value(a_v),
		.pin_group_b_value(b_v), .pin_group_base_value(base_v), .irq);
	mdi_apb_host host (.sys_clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] w);
		host.xfer(a, 1'b1, {16'h0000, w}, rdat, rerr);
	endtask
	task automatic rd(input logic [9:0] a);
		host.xfer(a, 1'b0, 32'h0, rdat, rerr);
	endtask

	initial begin
		#20000;
		num_errors++;
		stop_test;
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			@(posedge sys_clk);
			chk(32'(fault_flags), 32'(rows[i].f));
			chk(32'({a_v, b_v, base_v}), 32'(rows[i].p));
			rd(rows[i].a);
			chk(rdat, 32'(rows[i].r));
		end
		$display("table done");
		// test enable without its monitor enabled must stay silent
		mon_en <= '0;
		wr(10'h110, 16'h0004);
		@(posedge sys_clk);
		chk(32'(fault_flags), 32'h7F);
		mon_en <= '1;
		repeat (3) @(posedge sys_clk);
		chk(32'(fault_flags), 32'h3F);
		wr(10'h110, 16'h0000);
		wr(10'h140, 16'h007F);
		wr(10'h110, 16'h0004);
		repeat (3) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		wr(10'h144, 16'h0004);
		@(posedge sys_clk);
		chk(32'(irq), 32'h1);
		rd(10'h140);
		chk(rdat, 32'h4);
		rd(10'h148);
		chk(rdat, 32'h4);
		wr(10'h140, 16'h0004);
		@(posedge sys_clk);
		chk(32'(irq), 32'h0);
		wr(10'h110, 16'h0000);
		rd(10'h3FC);
		chk(32'(rerr), 32'h1);
		chk(rdat, 32'h0);
		$display("gating, interrupt and unmapped done");
		wr(10'h114, 16'h1234);
		chk(32'(crc_img.clock_check_injection), 32'h1234);
		wr(10'h118, 16'h0304);
		srst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		chk(32'(fault_flags), 32'h7F);
		rd(10'h114);
		chk(rdat, 32'h0);
		rd(10'h118);
		chk(rdat, 32'h0);
		$display("reset done");
		stop_test;
	end
endmodule // monitor_diagnostic_injection_tb_top
